/* design/cfc_regs.svh */
`ifndef CFC_REGS_SVH
`define CFC_REGS_SVH

// Exception vector of the control protection fault
`define CFC_FAULT_VECTOR 8'h15
// Privilege level that selects the user enable
`define CFC_CPL_USER 2'h3
// Shadow stack pointer steps in bytes
`define CFC_STEP_32 64'h0000_0000_0000_0004
`define CFC_STEP_64 64'h0000_0000_0000_0008
// Keeps addresses and pointer to 32 bits outside 64-bit mode
`define CFC_MASK_32 64'h0000_0000_ffff_ffff
`define CFC_MASK_64 64'hffff_ffff_ffff_ffff
// Shadow stack pointer after reset
`define CFC_SSP_RESET 64'h0000_0000_0001_0000
// Word index taken from pointer bit 2 upward
`define CFC_IDX_LSB 2

`endif

/* design/cfc_pkg.sv */
package cfc_pkg;

  typedef enum logic [3:0] {
    CFC_OP_OTHER,
    CFC_OP_CALL_NEAR,
    CFC_OP_CALL_FAR,
    CFC_OP_INT_ENTRY,
    CFC_OP_CALL_IND,
    CFC_OP_JMP_IND,
    CFC_OP_RET_NEAR,
    CFC_OP_RET_FAR,
    CFC_OP_IRET,
    CFC_OP_MARKER,
    CFC_OP_STORE
  } cfc_op_t;

  typedef enum logic [2:0] {
    CFC_CAUSE_NONE,
    CFC_CAUSE_MISSING_MARKER,
    CFC_CAUSE_PUSH_PAGE,
    CFC_CAUSE_POP_PAGE,
    CFC_CAUSE_RET_MISMATCH
  } cfc_cause_t;

  typedef enum {CFC_TRK_IDLE, CFC_TRK_AWAIT} cfc_trk_t;

  // One retiring instruction from the pipeline
  typedef struct packed {
    logic valid;
    cfc_op_t op;
    logic [63:0] ret_addr;
    logic [63:0] data_ret;
    logic page_ss;
  } cfc_instr_t;

  typedef struct packed {
    logic prot;
    logic v86;
    logic long64;
    logic [1:0] current_privilege_level;
    logic user_ss_en;
    logic sup_ss_en;
    logic track_en;
  } cfc_mode_t;

  typedef struct packed {
    logic fault;
    logic [7:0] vector;
    cfc_cause_t cause;
    logic done;
    logic ss_push;
    logic ss_pop;
    logic store_block;
    logic marker_nop;
  } cfc_result_t;

  typedef struct packed {
    logic [63:0] shadow_top_pointer;
    cfc_result_t res;
  } cfc_core_state_t;

  typedef struct packed {
    cfc_trk_t st;
  } cfc_trk_state_t;

endpackage

/* design/cfc_page_check.sv */
`timescale 1ns/1ps
`include "cfc_regs.svh"

module cfc_page_check (
  input wire cfc_pkg::cfc_op_t op_i,
  input wire logic valid_i,
  input wire logic ss_en_i,
  input wire logic page_ss_i,
  output logic push_fault_o,
  output logic pop_fault_o,
  output logic store_block_o
);

  logic is_push;
  logic is_pop;

  always_comb begin
    is_push = op_i inside {cfc_pkg::CFC_OP_CALL_NEAR, cfc_pkg::CFC_OP_CALL_FAR,
                           cfc_pkg::CFC_OP_INT_ENTRY, cfc_pkg::CFC_OP_CALL_IND};
    is_pop = op_i inside {cfc_pkg::CFC_OP_RET_NEAR, cfc_pkg::CFC_OP_RET_FAR,
                          cfc_pkg::CFC_OP_IRET};
    push_fault_o = valid_i && ss_en_i && is_push && !page_ss_i;
    pop_fault_o = valid_i && ss_en_i && is_pop && !page_ss_i;
    // Plain stores never touch a shadow page, whatever the enables say
    store_block_o = valid_i && (op_i == cfc_pkg::CFC_OP_STORE) && page_ss_i;
  end

endmodule

/* design/cfc_branch_tracker.sv */
`timescale 1ns/1ps
`include "cfc_regs.svh"

module cfc_branch_tracker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic valid_i,
  input wire cfc_pkg::cfc_op_t op_i,
  input wire logic track_en_i,
  input wire logic fault_taken_i,
  output logic awaiting_target_marker_o,
  output logic miss_o
);

  cfc_pkg::cfc_trk_state_t q;
  cfc_pkg::cfc_trk_state_t next_q;
  logic indirect;

  always_comb begin
    next_q = q;
    indirect = (op_i == cfc_pkg::CFC_OP_JMP_IND) || (op_i == cfc_pkg::CFC_OP_CALL_IND);
    miss_o = valid_i && (q.st == cfc_pkg::CFC_TRK_AWAIT)
             && (op_i != cfc_pkg::CFC_OP_MARKER);
    if (valid_i) begin
      unique case (q.st)
        cfc_pkg::CFC_TRK_IDLE: begin
          if (!fault_taken_i && indirect && track_en_i) begin
            next_q.st = cfc_pkg::CFC_TRK_AWAIT;
          end
        end
        cfc_pkg::CFC_TRK_AWAIT: begin
          next_q.st = cfc_pkg::CFC_TRK_IDLE;
        end
      endcase
      if (fault_taken_i) begin
        next_q.st = cfc_pkg::CFC_TRK_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q.st <= cfc_pkg::CFC_TRK_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign awaiting_target_marker_o = (q.st == cfc_pkg::CFC_TRK_AWAIT);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_enter_await: assert property (
    valid_i && !fault_taken_i && indirect && track_en_i && q.st == cfc_pkg::CFC_TRK_IDLE
    |=> awaiting_target_marker_o)
    else $error("indirect branch did not arm the tracker");
  a_marker_idle: assert property (
    valid_i && awaiting_target_marker_o && op_i == cfc_pkg::CFC_OP_MARKER
    |-> !miss_o ##1 !awaiting_target_marker_o)
    else $error("marker did not return tracker to idle");
  a_fault_idle: assert property (
    valid_i && fault_taken_i |=> !awaiting_target_marker_o)
    else $error("tracker not idle after fault");

  c_marker_seen: cover property (awaiting_target_marker_o && valid_i && !miss_o);

endmodule

/* design/cfc_checker.sv */
`timescale 1ns/1ps
`include "cfc_regs.svh"

module cfc_checker #(
  parameter int DEPTH = 16,
  parameter int IDXW = $clog2(DEPTH),
  parameter logic [63:0] SSP_RESET = `CFC_SSP_RESET
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire cfc_pkg::cfc_instr_t instr_i,
  input wire cfc_pkg::cfc_mode_t mode_i,
  output logic [63:0] ss_addr_o,
  output cfc_pkg::cfc_result_t result_o,
  output logic [63:0] shadow_top_pointer_o,
  output logic awaiting_target_marker_o
);

  cfc_pkg::cfc_core_state_t q;
  cfc_pkg::cfc_core_state_t next_q;
  logic [63:0] mem [DEPTH];

  logic ss_en;
  logic [63:0] step;
  logic [63:0] amask;
  logic [63:0] push_ptr;
  logic [63:0] popped;
  logic [63:0] dret;
  logic is_push;
  logic is_pop;
  logic push_fault;
  logic pop_fault;
  logic store_block;
  logic trk_miss;
  logic fault_now;
  logic wr_en;
  logic [IDXW-1:0] wr_idx;
  logic [IDXW-1:0] rd_idx;
  logic [63:0] wr_data;

  always_comb begin
    ss_en = 1'b0;
    if (mode_i.prot && !mode_i.v86) begin
      if (mode_i.current_privilege_level == `CFC_CPL_USER) begin
        ss_en = mode_i.user_ss_en;
      end else begin
        ss_en = mode_i.sup_ss_en;
      end
    end
    step = mode_i.long64 ? `CFC_STEP_64 : `CFC_STEP_32;
    amask = mode_i.long64 ? `CFC_MASK_64 : `CFC_MASK_32;
    // Mask after the step so a 32-bit pointer wraps within 32 bits
    push_ptr = (q.shadow_top_pointer - step) & amask;
    is_push = instr_i.op inside {cfc_pkg::CFC_OP_CALL_NEAR, cfc_pkg::CFC_OP_CALL_FAR,
                                 cfc_pkg::CFC_OP_INT_ENTRY, cfc_pkg::CFC_OP_CALL_IND};
    is_pop = instr_i.op inside {cfc_pkg::CFC_OP_RET_NEAR, cfc_pkg::CFC_OP_RET_FAR,
                                cfc_pkg::CFC_OP_IRET};
    // The paging side translates this address and answers with page_ss
    ss_addr_o = is_push ? push_ptr : q.shadow_top_pointer;
    // Nesting deeper than DEPTH (DEPTH/2 with the 8-byte step of 64-bit mode) overwrites old entries; no overflow fault is raised
    rd_idx = q.shadow_top_pointer[`CFC_IDX_LSB +: IDXW];
    popped = mem[rd_idx] & amask;
    dret = instr_i.data_ret & amask;
  end

  cfc_page_check u_page_check (
    .op_i(instr_i.op),
    .valid_i(instr_i.valid),
    .ss_en_i(ss_en),
    .page_ss_i(instr_i.page_ss),
    .push_fault_o(push_fault),
    .pop_fault_o(pop_fault),
    .store_block_o(store_block)
  );

  cfc_branch_tracker u_tracker (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .valid_i(instr_i.valid),
    .op_i(instr_i.op),
    .track_en_i(mode_i.track_en),
    .fault_taken_i(fault_now),
    .awaiting_target_marker_o(awaiting_target_marker_o),
    .miss_o(trk_miss)
  );

  always_comb begin
    next_q = q;
    next_q.res = '0;
    fault_now = 1'b0;
    wr_en = 1'b0;
    wr_idx = push_ptr[`CFC_IDX_LSB +: IDXW];
    wr_data = instr_i.ret_addr & amask;
    if (instr_i.valid) begin
      // A missing marker outranks the checks of the faulting instruction itself
      if (trk_miss) begin
        fault_now = 1'b1;
        next_q.res.cause = cfc_pkg::CFC_CAUSE_MISSING_MARKER;
      end else if (push_fault) begin
        fault_now = 1'b1;
        next_q.res.cause = cfc_pkg::CFC_CAUSE_PUSH_PAGE;
      end else if (pop_fault) begin
        fault_now = 1'b1;
        next_q.res.cause = cfc_pkg::CFC_CAUSE_POP_PAGE;
      end else if (ss_en && is_pop && (popped != dret)) begin
        fault_now = 1'b1;
        next_q.res.cause = cfc_pkg::CFC_CAUSE_RET_MISMATCH;
      end else begin
        next_q.res.done = 1'b1;
        if (ss_en && is_push) begin
          wr_en = 1'b1;
          next_q.shadow_top_pointer = push_ptr;
          next_q.res.ss_push = 1'b1;
        end
        if (ss_en && is_pop) begin
          next_q.shadow_top_pointer = (q.shadow_top_pointer + step) & amask;
          next_q.res.ss_pop = 1'b1;
        end
        if (store_block) begin
          next_q.res.done = 1'b0;
          next_q.res.store_block = 1'b1;
        end
        // Marker retires with no architectural effect
        next_q.res.marker_nop = (instr_i.op == cfc_pkg::CFC_OP_MARKER);
      end
      if (fault_now) begin
        next_q.res.fault = 1'b1;
        next_q.res.vector = `CFC_FAULT_VECTOR;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q.shadow_top_pointer <= SSP_RESET;
      q.res <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Storage only; no reset so it maps to plain RAM
  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  assign result_o = q.res;
  assign shadow_top_pointer_o = q.shadow_top_pointer;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_fault_vector: assert property (
    result_o.fault |-> result_o.vector == 8'h15 && !result_o.done)
    else $error("fault not on vector 21 or also completed");
  a_ret_mismatch: assert property (
    instr_i.valid && !trk_miss && !pop_fault && ss_en && is_pop && popped != dret
    |=> result_o.fault && result_o.cause == cfc_pkg::CFC_CAUSE_RET_MISMATCH)
    else $error("mismatched return not faulted");
  a_push_moves: assert property (
    instr_i.valid && !trk_miss && !push_fault && ss_en && is_push
    |=> result_o.ss_push && shadow_top_pointer_o == $past(push_ptr))
    else $error("call did not push shadow stack");
  a_push_value: assert property (
    instr_i.valid && !trk_miss && !push_fault && ss_en && is_push
    |=> mem[$past(wr_idx)] == ($past(instr_i.ret_addr) & $past(amask)))
    else $error("shadow entry is not the return address");
  a_pop_moves: assert property (
    result_o.ss_pop |-> shadow_top_pointer_o == (($past(shadow_top_pointer_o)
                        + $past(step)) & $past(amask)))
    else $error("return did not pop shadow stack");
  a_push_page: assert property (
    instr_i.valid && ss_en && is_push && !instr_i.page_ss
    |=> result_o.fault && !result_o.ss_push)
    else $error("push to non-shadow page not faulted");
  a_pop_page: assert property (
    instr_i.valid && ss_en && is_pop && !instr_i.page_ss |=> result_o.fault)
    else $error("pop from non-shadow page not faulted");
  a_store_block: assert property (
    instr_i.valid && !trk_miss && instr_i.op == cfc_pkg::CFC_OP_STORE && instr_i.page_ss
    |=> result_o.store_block && !result_o.done)
    else $error("store to shadow page not blocked");
  a_v86_off: assert property (
    instr_i.valid && (mode_i.v86 || !mode_i.prot) |=> !result_o.ss_push && !result_o.ss_pop)
    else $error("shadow stack used outside protected mode");
  a_privilege_en: assert property (
    instr_i.valid && mode_i.prot && !mode_i.v86 && is_push
    && mode_i.current_privilege_level == 2'h3 && !mode_i.user_ss_en |=> !result_o.ss_push)
    else $error("user push with user enable clear");
  a_width_32: assert property (
    !mode_i.long64 && result_o.ss_push |-> shadow_top_pointer_o[63:32] == 32'h0)
    else $error("pointer exceeds 32 bits outside 64-bit mode");
  a_marker_nop: assert property (
    instr_i.valid && !trk_miss && instr_i.op == cfc_pkg::CFC_OP_MARKER
    |=> result_o.marker_nop && $stable(shadow_top_pointer_o))
    else $error("marker had an effect");
  a_miss_fault: assert property (
    trk_miss |=> result_o.fault && result_o.cause == cfc_pkg::CFC_CAUSE_MISSING_MARKER)
    else $error("missing marker not faulted");

  // Outcome of each retired instruction
  a_done_alone: assert property (
    result_o.done |-> !result_o.fault && !result_o.store_block)
    else $error("completed instruction also faulted or blocked");
  a_fault_still: assert property (
    result_o.fault |-> !result_o.ss_push && !result_o.ss_pop && $stable(shadow_top_pointer_o))
    else $error("faulting instruction moved the shadow stack");
  a_cause_fault: assert property (
    (result_o.cause != cfc_pkg::CFC_CAUSE_NONE) == result_o.fault)
    else $error("fault flag and cause disagree");
  a_vector_idle: assert property (
    !result_o.fault |-> result_o.vector == 8'h00)
    else $error("vector shown without a fault");
  a_marker_plain: assert property (
    result_o.marker_nop |-> result_o.done && !result_o.ss_push && !result_o.ss_pop)
    else $error("marker touched the shadow stack");
  a_miss_still: assert property (
    trk_miss |=> !result_o.done && $stable(shadow_top_pointer_o))
    else $error("missing marker still completed");

  // Stack contents, pointer and address
  a_pop_match: assert property (
    instr_i.valid && !trk_miss && !pop_fault && ss_en && is_pop && popped == dret
    |=> result_o.ss_pop && result_o.done)
    else $error("matching return did not complete");
  a_push_write: assert property (
    instr_i.valid && !trk_miss && !push_fault && ss_en && is_push
    |-> wr_en && wr_data == (instr_i.ret_addr & amask))
    else $error("call did not write its return address");
  a_write_push: assert property (
    wr_en |-> instr_i.valid && ss_en && is_push && !fault_now)
    else $error("shadow storage written outside a push");
  a_push_step_64: assert property (
    result_o.ss_push && $past(mode_i.long64)
    |-> shadow_top_pointer_o == $past(shadow_top_pointer_o) - `CFC_STEP_64)
    else $error("64-bit push did not move pointer by 8");
  a_push_step_32: assert property (
    result_o.ss_push && !$past(mode_i.long64)
    |-> shadow_top_pointer_o == (($past(shadow_top_pointer_o) - `CFC_STEP_32) & `CFC_MASK_32))
    else $error("32-bit push did not move pointer by 4");
  a_pop_step_64: assert property (
    result_o.ss_pop && $past(mode_i.long64)
    |-> shadow_top_pointer_o == $past(shadow_top_pointer_o) + `CFC_STEP_64)
    else $error("64-bit return did not move pointer by 8");
  a_addr_32: assert property (
    instr_i.valid && !mode_i.long64 && is_push |-> ss_addr_o[63:32] == 32'h0)
    else $error("push address exceeds 32 bits outside 64-bit mode");
  a_pop_read: assert property (
    instr_i.valid && is_pop |-> ss_addr_o == shadow_top_pointer_o)
    else $error("return reads away from the stack top");

  // Page attribute
  a_pop_page_still: assert property (
    instr_i.valid && ss_en && is_pop && !instr_i.page_ss
    |=> !result_o.ss_pop && $stable(shadow_top_pointer_o))
    else $error("pop from non-shadow page moved the pointer");
  a_push_page_keep: assert property (
    instr_i.valid && ss_en && is_push && !instr_i.page_ss |-> !wr_en)
    else $error("push wrote a non-shadow page");
  a_store_free: assert property (
    instr_i.valid && !trk_miss && instr_i.op == cfc_pkg::CFC_OP_STORE && !instr_i.page_ss
    |=> result_o.done && !result_o.store_block)
    else $error("store to ordinary page was blocked");
  a_store_no_stack: assert property (
    instr_i.valid && instr_i.op == cfc_pkg::CFC_OP_STORE |-> !wr_en)
    else $error("plain store wrote shadow storage");

  // Mode enables; user and supervisor never borrow each other's enable
  a_sup_en: assert property (
    instr_i.valid && mode_i.prot && !mode_i.v86 && is_push
    && mode_i.current_privilege_level != `CFC_CPL_USER && !mode_i.sup_ss_en
    |=> !result_o.ss_push)
    else $error("supervisor push with supervisor enable clear");
  a_user_indep: assert property (
    instr_i.valid && !trk_miss && mode_i.prot && !mode_i.v86 && is_push && instr_i.page_ss
    && mode_i.current_privilege_level == `CFC_CPL_USER && mode_i.user_ss_en
    |=> result_o.ss_push)
    else $error("user push skipped with user enable set");
  a_sup_indep: assert property (
    instr_i.valid && !trk_miss && mode_i.prot && !mode_i.v86 && is_push && instr_i.page_ss
    && mode_i.current_privilege_level != `CFC_CPL_USER && mode_i.sup_ss_en
    |=> result_o.ss_push)
    else $error("supervisor push skipped with supervisor enable set");
  a_v86_nowrite: assert property (
    instr_i.valid && (mode_i.v86 || !mode_i.prot) |-> !wr_en)
    else $error("shadow storage written outside protected mode");
  a_off_no_fault: assert property (
    instr_i.valid && mode_i.v86 && !trk_miss && is_push |=> !result_o.fault)
    else $error("disabled shadow stack raised a page fault");

  // Main scenarios
  c_call_ret: cover property (result_o.ss_push ##[1:8] result_o.ss_pop);
  c_mismatch: cover property (result_o.cause == cfc_pkg::CFC_CAUSE_RET_MISMATCH);
  c_missing: cover property (result_o.cause == cfc_pkg::CFC_CAUSE_MISSING_MARKER);
  c_store_block: cover property (result_o.store_block);

endmodule

/* testbench/cfc_pipe_model.sv */
`timescale 1ns/1ps

module cfc_pipe_model (
  input wire cfc_pkg::cfc_instr_t req_i,
  input wire logic bad_page_i,
  output cfc_pkg::cfc_instr_t instr_o
);
  always_comb begin
    instr_o = req_i;
    // Wrong attribute only when the bench asks for it
    instr_o.page_ss = req_i.page_ss & !bad_page_i;
    if (!req_i.valid) begin
      // Idle payload is inverted so a stale value never looks live
      instr_o = ~req_i;
      instr_o.valid = 1'b0;
    end
  end
endmodule

/* testbench/test_control_flow_checker.sv */
`timescale 1ns/1ps
`include "cfc_regs.svh"

module test_control_flow_checker;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic bad = 1'b0;
  cfc_pkg::cfc_instr_t req = '0;
  cfc_pkg::cfc_instr_t instr;
  cfc_pkg::cfc_mode_t mode = '0;
  cfc_pkg::cfc_result_t res;
  logic [63:0] ptr_o;
  logic [63:0] addr_o;
  logic await_o;
  int err_total = 0;
  int n_compared = 0;
  logic [63:0] ptr;
  logic armed;
  logic [63:0] mem [16];
  logic [15:0] mem_ok;

  always #12.5 clk_i = ~clk_i;

  cfc_pipe_model u_cfc_pipe_model (.req_i(req), .bad_page_i(bad), .instr_o(instr));
  cfc_checker u_cfc_checker (.clk_i(clk_i), .rstn_i(rstn_i), .instr_i(instr), .mode_i(mode),
    .ss_addr_o(addr_o), .result_o(res), .shadow_top_pointer_o(ptr_o),
    .awaiting_target_marker_o(await_o));

  task automatic chk_res(input cfc_pkg::cfc_result_t got, input cfc_pkg::cfc_result_t exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t result %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic ss_en();
    return mode.prot && !mode.v86 && (mode.current_privilege_level == `CFC_CPL_USER ?
      mode.user_ss_en : mode.sup_ss_en);
  endfunction

  task automatic do_reset();
    // Called on a falling edge: drop the last request before another edge can take it
    rstn_i = 1'b0;
    req.valid = 1'b0;
    repeat (6) @(negedge clk_i);
    chk_res(res, '0);
    chk_val(ptr_o, `CFC_SSP_RESET);
    chk_val({63'h0, await_o}, 64'h0);
    rstn_i = 1'b1;
    ptr = `CFC_SSP_RESET;
    armed = 1'b0;
    mem_ok = '0;
    for (int j = 0; j < 16; j++) mem[j] = '0;
    @(negedge clk_i);
  endtask

  task automatic step(input cfc_pkg::cfc_op_t op, input logic [63:0] ra,
                      input logic [63:0] dr, input logic pg);
    logic en, push, pop;
    logic [63:0] m, st, wa, ea;
    logic [3:0] i;
    cfc_pkg::cfc_cause_t c;
    cfc_pkg::cfc_result_t er;
    m = mode.long64 ? `CFC_MASK_64 : `CFC_MASK_32;
    st = mode.long64 ? `CFC_STEP_64 : `CFC_STEP_32;
    en = ss_en();
    push = en && op inside {[cfc_pkg::CFC_OP_CALL_NEAR:cfc_pkg::CFC_OP_CALL_IND]};
    pop = en && op inside {[cfc_pkg::CFC_OP_RET_NEAR:cfc_pkg::CFC_OP_IRET]};
    wa = push ? ((ptr - st) & m) : ptr;
    i = wa[5:2];
    req = '{valid: 1'b1, op: op, ret_addr: ra, data_ret: dr, page_ss: 1'b1};
    bad = !pg;
    ea = ptr;
    if (op inside {[cfc_pkg::CFC_OP_CALL_NEAR:cfc_pkg::CFC_OP_CALL_IND]}) ea = (ptr - st) & m;
    #1;
    chk_val(addr_o, ea);
    c = cfc_pkg::CFC_CAUSE_NONE;
    if (armed && op != cfc_pkg::CFC_OP_MARKER) c = cfc_pkg::CFC_CAUSE_MISSING_MARKER;
    else if (push && !pg) c = cfc_pkg::CFC_CAUSE_PUSH_PAGE;
    else if (pop && !pg) c = cfc_pkg::CFC_CAUSE_POP_PAGE;
    else if (pop && mem[i] !== (dr & m)) c = cfc_pkg::CFC_CAUSE_RET_MISMATCH;
    er = '0;
    if (c != cfc_pkg::CFC_CAUSE_NONE) begin
      er.fault = 1'b1;
      er.vector = `CFC_FAULT_VECTOR;
      er.cause = c;
    end else if (op == cfc_pkg::CFC_OP_STORE && pg) begin
      er.store_block = 1'b1;
    end else begin
      er.done = 1'b1;
      er.ss_push = push;
      er.ss_pop = pop;
      er.marker_nop = (op == cfc_pkg::CFC_OP_MARKER);
      if (push) begin
        mem[i] = ra & m;
        mem_ok[i] = 1'b1;
        ptr = wa;
      end
      if (pop) ptr = (ptr + st) & m;
    end
    armed = (c == cfc_pkg::CFC_CAUSE_NONE) && mode.track_en &&
      op inside {[cfc_pkg::CFC_OP_CALL_IND:cfc_pkg::CFC_OP_JMP_IND]};
    @(negedge clk_i);
    chk_res(res, er);
    chk_val(ptr_o, ptr);
    chk_val({63'h0, await_o}, {63'h0, armed});
  endtask

  task automatic run_phase(input logic l64, input int n);
    cfc_pkg::cfc_op_t op;
    cfc_pkg::cfc_mode_t md;
    logic [63:0] ra, dr;
    do_reset();
    for (int k = 0; k < n; k++) begin
      md = cfc_pkg::cfc_mode_t'(8'($urandom));
      md.prot = ($urandom_range(9) != 0);
      md.v86 = ($urandom_range(9) == 0);
      md.long64 = l64;
      mode = md;
      op = cfc_pkg::cfc_op_t'($urandom_range(10));
      if (armed && $urandom_range(1) == 1) op = cfc_pkg::CFC_OP_MARKER;
      // A pop from a never written entry has no defined value
      if (ss_en() && op inside {[cfc_pkg::CFC_OP_RET_NEAR:cfc_pkg::CFC_OP_IRET]} &&
          !mem_ok[ptr[5:2]]) op = cfc_pkg::CFC_OP_CALL_NEAR;
      ra = {$urandom, $urandom};
      dr = mem[ptr[5:2]] ^ {63'h0, ($urandom_range(9) == 0)};
      step(op, ra, dr, $urandom_range(9) != 0);
    end
    $display("random phase long64=%0d done, errors %0d", l64, err_total);
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #(25ns * 6000);
    err_total++;
    results();
  end

  initial begin
    void'($urandom(96));
    do_reset();
    mode = '{prot: 1'b1, v86: 1'b0, long64: 1'b1, current_privilege_level: 2'h3,
      user_ss_en: 1'b1, sup_ss_en: 1'b0, track_en: 1'b1};
    step(cfc_pkg::CFC_OP_CALL_IND, 64'h0123_4567_89ab_cdef, 64'h0, 1'b1);
    step(cfc_pkg::CFC_OP_RET_NEAR, 64'h0, 64'h0123_4567_89ab_cdee, 1'b1);
    step(cfc_pkg::CFC_OP_CALL_NEAR, 64'h0000_0000_0000_1000, 64'h0, 1'b0);
    step(cfc_pkg::CFC_OP_JMP_IND, 64'h0, 64'h0, 1'b1);
    step(cfc_pkg::CFC_OP_MARKER, 64'h0, 64'h0, 1'b1);
    step(cfc_pkg::CFC_OP_STORE, 64'h0, 64'h0, 1'b1);
    step(cfc_pkg::CFC_OP_RET_NEAR, 64'h0, 64'h0123_4567_89ab_cdef, 1'b0);
    step(cfc_pkg::CFC_OP_RET_NEAR, 64'h0, 64'h0123_4567_89ab_cdef, 1'b1);
    $display("corner test done, errors %0d", err_total);
    run_phase(1'b1, 400);
    run_phase(1'b0, 400);
    results();
  end
endmodule
